// *** atarc_core.sv ***
/*
  ATA read-command handler: task file on APB, sector buffer, media fetch port.
  Assumes the media port and NATIVE_MAX are driven by logic on CLK.
*/
// The APB interface to the registers and the address map were left to the implementer.
module atarc_core import atarc_pkg::*; (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ATARC_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic MED_REQ,
  output logic [ATARC_LBA_W-1:0] MED_LBA,
  input wire logic MED_VALID,
  input wire logic [31:0] MED_DATA,
  input wire logic MED_DONE,
  input wire logic MED_ERR,
  input wire logic [ATARC_LBA_W-1:0] NATIVE_MAX
);

  function automatic logic [ATARC_LBA_W-1:0] lba_of(input atarc_addr_t a);
    lba_of = {a.head, a.high, a.mid, a.low};
  endfunction

  function automatic logic is_op(input logic [7:0] op, input logic [7:0] a,
                                 input logic [7:0] b);
    is_op = (op == a) || (op == b);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  //////////////////////////////////////////////////////////////////////////////
  // State

  atarc_state_t state_reg, state_next;
  atarc_addr_t addr_reg, addr_next;
  logic [7:0] feature_reg, count_reg, count_next, dh_top_reg;
  logic [ATARC_LBA_W-1:0] cur_lba_reg, cur_lba_next;
  logic [ATARC_CNT_W-1:0] remain_reg, remain_next;
  logic [ATARC_WIDX_W:0] widx_reg;
  logic [ATARC_WIDX_W-1:0] ridx_reg;
  logic verify_reg, err_reg, med_req_reg;
  logic [ATARC_LBA_W-1:0] med_lba_reg;
  logic [2:0] irq_sts_reg, irq_mask_reg, irq_set;
  logic [31:0] buf_mem [ATARC_SECT_WORDS];

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire acc = PSEL && PENABLE;
  wire wr_acc = acc && PWRITE;
  wire rd_acc = acc && !PWRITE;
  wire [7:0] wbyte = PWDATA[7:0];
  wire idle = (state_reg == ST_IDLE);
  wire host_wr = wr_acc && idle;
  // Unmapped offsets answer PSLVERR and change nothing
  wire mapped = (PADDR == OFF_DATA) || (PADDR == OFF_FEATURE) || (PADDR == OFF_COUNT)
    || (PADDR == OFF_ADDR_LOW) || (PADDR == OFF_ADDR_MID) || (PADDR == OFF_ADDR_HIGH)
    || (PADDR == OFF_DEV_HEAD) || (PADDR == OFF_CMD_STAT) || (PADDR == OFF_IRQ_STS)
    || (PADDR == OFF_IRQ_MASK);

  // Command accepted only when idle; a write while busy is dropped
  wire cmd_wr = host_wr && (PADDR == OFF_CMD_STAT);
  wire cmd_native = cmd_wr && (wbyte == OP_NATIVE_MAX);
  wire cmd_read = cmd_wr && is_op(wbyte, OP_READ_A, OP_READ_B);
  wire cmd_verify = cmd_wr && is_op(wbyte, OP_VERIFY_A, OP_VERIFY_B);
  wire cmd_recal = cmd_wr && (wbyte[7:4] == OP_RECAL_HI);
  wire cmd_bad = cmd_wr && !cmd_native && !cmd_read && !cmd_verify && !cmd_recal;
  wire cmd_sect = cmd_read || cmd_verify;

  wire fetch_end = (state_reg == ST_FETCH) && MED_DONE;
  wire fetch_err = fetch_end && MED_ERR;
  wire fetch_ok = fetch_end && !MED_ERR;
  wire last = (remain_reg == CNT_ONE);
  wire data_rd = rd_acc && (PADDR == OFF_DATA) && (state_reg != ST_FETCH);
  wire host_last = data_rd && (state_reg == ST_XFER) && (ridx_reg == WIDX_LAST);
  wire ver_ok = fetch_ok && verify_reg;
  wire adv = ver_ok || host_last;
  wire refetch = adv && !last;

  atarc_stat_t stat;
  assign stat.busy = (state_reg == ST_FETCH);
  assign stat.drq = (state_reg == ST_XFER);
  assign stat.err = err_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (cmd_sect) begin
          state_next = ST_FETCH; // R8 R13
        end
      end
      ST_FETCH: begin
        if (fetch_err || (ver_ok && last)) begin
          state_next = ST_IDLE; // R10 R13 R14
        end else if (fetch_ok && !verify_reg) begin
          state_next = ST_XFER; // R8
        end
      end
      ST_XFER: begin
        if (host_last) begin
          state_next = last ? ST_IDLE : ST_FETCH; // R8
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Start from the task file, then walk consecutive sectors
  assign cur_lba_next = cmd_sect ? lba_of(addr_reg) // R7 R17
    : (adv ? cur_lba_reg + LBA_ONE : cur_lba_reg); // R18
  assign remain_next = cmd_sect ? ((count_reg == 8'h00) ? CNT_FULL // R5 R6
    : {1'b0, count_reg}) : (adv ? remain_reg - CNT_ONE : remain_reg); // R18

  // Device-side updates of the address block win over the host
  always_comb begin
    addr_next = addr_reg;
    count_next = count_reg;
    if (cmd_native) begin
      addr_next = NATIVE_MAX; // R1 R4
    end else if (fetch_err) begin
      addr_next = cur_lba_reg; // R10 R14
      count_next = remain_reg[7:0]; // R15
    end else if (host_wr) begin
      if (PADDR == OFF_ADDR_LOW) addr_next.low = wbyte;
      if (PADDR == OFF_ADDR_MID) addr_next.mid = wbyte;
      if (PADDR == OFF_ADDR_HIGH) addr_next.high = wbyte;
      if (PADDR == OFF_DEV_HEAD) addr_next.head = wbyte[3:0];
      if (PADDR == OFF_COUNT) count_next = wbyte;
    end
  end

  assign irq_set[IRQ_SECT] = fetch_ok && !verify_reg; // R8
  assign irq_set[IRQ_DONE] = cmd_native || cmd_recal || (ver_ok && last); // R13 R16
  assign irq_set[IRQ_ERR] = fetch_err || cmd_bad;

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      addr_reg <= '0;
      count_reg <= 8'h00;
      feature_reg <= 8'h00;
      dh_top_reg <= 8'h00;
      cur_lba_reg <= '0;
      remain_reg <= '0;
      verify_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      count_reg <= count_next;
      cur_lba_reg <= cur_lba_next;
      remain_reg <= remain_next;
      if (host_wr && (PADDR == OFF_FEATURE)) feature_reg <= wbyte;
      if (host_wr && (PADDR == OFF_DEV_HEAD)) dh_top_reg <= {wbyte[7:4], 4'h0};
      if (cmd_wr) verify_reg <= cmd_verify; // R12
    end
  end

  // Error flag: a new command clears it, an error sets it
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= 1'b0;
    end else if (fetch_err || cmd_bad) begin
      err_reg <= 1'b1;
    end else if (cmd_wr) begin
      err_reg <= 1'b0;
    end
  end

  // Media request pulses once per sector
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      med_req_reg <= 1'b0;
      med_lba_reg <= '0;
    end else begin
      med_req_reg <= cmd_sect || refetch; // R8 R18
      med_lba_reg <= cur_lba_next;
    end
  end
  assign MED_REQ = med_req_reg;
  assign MED_LBA = med_lba_reg;

  // Fill index saturates so surplus media words cannot overwrite the sector
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      widx_reg <= '0;
      ridx_reg <= '0;
    end else begin
      if (med_req_reg) begin
        widx_reg <= '0;
      end else if (MED_VALID && (state_reg == ST_FETCH) && !widx_reg[ATARC_WIDX_W]) begin
        widx_reg <= widx_reg + 1'b1;
      end
      if (fetch_end) begin
        ridx_reg <= '0; // R11
      end else if (data_rd) begin
        ridx_reg <= ridx_reg + 1'b1;
      end
    end
  end

  // Buffer keeps the last fetched sector, flawed or not
  always_ff @(posedge CLK) begin
    if (MED_VALID && (state_reg == ST_FETCH) && !widx_reg[ATARC_WIDX_W]) begin
      buf_mem[widx_reg[ATARC_WIDX_W-1:0]] <= MED_DATA; // R11
    end
  end

  // Sticky interrupt status: set beats a same-cycle write-one clear
  wire sts_clr = wr_acc && (PADDR == OFF_IRQ_STS);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      irq_sts_reg <= (irq_sts_reg & ~(sts_clr ? PWDATA[2:0] : 3'h0)) | irq_set;
      if (wr_acc && (PADDR == OFF_IRQ_MASK)) irq_mask_reg <= PWDATA[2:0];
    end
  end
  assign IRQ = |(irq_sts_reg & irq_mask_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; the buffer is read directly, so a read right after a fetch is never stale

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (PADDR)
      OFF_DATA: rdata = buf_mem[ridx_reg];
      OFF_FEATURE: rdata = {24'h000000, feature_reg};
      OFF_COUNT: rdata = {24'h000000, count_reg};
      OFF_ADDR_LOW: rdata = {24'h000000, addr_reg.low};
      OFF_ADDR_MID: rdata = {24'h000000, addr_reg.mid};
      OFF_ADDR_HIGH: rdata = {24'h000000, addr_reg.high};
      OFF_DEV_HEAD: rdata = {24'h000000, dh_top_reg[7:4], addr_reg.head};
      OFF_CMD_STAT: rdata = {29'h00000000, stat};
      OFF_IRQ_STS: rdata = {29'h00000000, irq_sts_reg};
      OFF_IRQ_MASK: rdata = {29'h00000000, irq_mask_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end
  assign PRDATA = rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !mapped;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);
  // All checks sleep while the internal reset is low

  property p_native;
    cmd_native |=> (lba_of(addr_reg) == $past(NATIVE_MAX)) && idle && irq_sts_reg[IRQ_DONE];
  endproperty
  a_native: assert property (p_native) else $error("native max not loaded"); // R4

  property p_count_zero;
    cmd_sect && (count_reg == 8'h00) |=> remain_reg == CNT_FULL;
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("zero count not 256"); // R6

  property p_start;
    cmd_sect |=> MED_REQ && (MED_LBA == $past(lba_of(addr_reg))) && stat.busy;
  endproperty
  a_start: assert property (p_start) else $error("bad start address"); // R17

  property p_sector_ready;
    fetch_ok && !verify_reg |=> stat.drq && !stat.busy && irq_sts_reg[IRQ_SECT];
  endproperty
  a_sector_ready: assert property (p_sector_ready) else $error("no data request"); // R8

  property p_err_addr;
    fetch_err |=> (lba_of(addr_reg) == $past(cur_lba_reg)) && idle && err_reg;
  endproperty
  a_err_addr: assert property (p_err_addr) else $error("error address wrong"); // R10

  property p_verify_nodrq;
    verify_reg |-> !stat.drq;
  endproperty
  a_verify_nodrq: assert property (p_verify_nodrq) else $error("verify raised drq"); // R12

  property p_verify_left;
    fetch_err && verify_reg |=> count_reg == $past(remain_reg[7:0]);
  endproperty
  a_verify_left: assert property (p_verify_left) else $error("unverified count wrong"); // R15

  property p_verify_done;
    ver_ok && last |=> idle ##0 irq_sts_reg[IRQ_DONE];
  endproperty
  a_verify_done: assert property (p_verify_done) else $error("verify end wrong"); // R13

  property p_recal;
    cmd_recal |=> $stable(addr_reg) && $stable(count_reg) && idle;
  endproperty
  a_recal: assert property (p_recal) else $error("recalibrate changed state"); // R16

  property p_advance;
    refetch |=> (remain_reg == $past(remain_reg) - CNT_ONE)
      && (MED_LBA == $past(cur_lba_reg) + LBA_ONE) ##1 !MED_REQ;
  endproperty
  a_advance: assert property (p_advance) else $error("sector advance wrong"); // R18

  property p_native_nodata;
    cmd_native |=> !MED_REQ && !stat.drq && !stat.busy;
  endproperty
  a_native_nodata: assert property (p_native_nodata) else $error("native query moved data"); // R1

  property p_read_count;
    cmd_read && (count_reg != 8'h00) |=> remain_reg == {1'b0, $past(count_reg)};
  endproperty
  a_read_count: assert property (p_read_count) else $error("read count not taken"); // R5

  property p_next_sector;
    host_last && !last |=> stat.busy && !stat.drq && MED_REQ;
  endproperty
  a_next_sector: assert property (p_next_sector) else $error("next sector not fetched"); // R8

  property p_last_read;
    host_last && last |=> idle && !MED_REQ;
  endproperty
  a_last_read: assert property (p_last_read) else $error("read did not end"); // R8

  property p_set_wins;
    (|irq_set) |=> (irq_sts_reg & $past(irq_set)) == $past(irq_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("interrupt event lost"); // R13

  property p_flaw_kept;
    fetch_err |=> (ridx_reg == '0) && !stat.busy && !stat.drq;
  endproperty
  a_flaw_kept: assert property (p_flaw_kept) else $error("flawed sector not rewound"); // R11

  property p_verify_next;
    ver_ok && !last |=> stat.busy && !stat.drq && MED_REQ;
  endproperty
  a_verify_next: assert property (p_verify_next) else $error("verify did not go on"); // R13

  property p_verify_err;
    fetch_err && verify_reg |=> (lba_of(addr_reg) == $past(cur_lba_reg))
      && idle && irq_sts_reg[IRQ_ERR];
  endproperty
  a_verify_err: assert property (p_verify_err) else $error("verify error wrong"); // R14

  property p_remain_live;
    !idle |-> (remain_reg != '0) && (remain_reg <= CNT_FULL);
  endproperty
  a_remain_live: assert property (p_remain_live) else $error("remaining count out of range"); // R18

endmodule // atarc_core

// *** atarc_media_model.sv ***
/*
  Media-side model of the read-command handler: answers each fetch with 128 words.
  Assumes the design's clock and reset; err_lba names the one sector that fails.
*/
module atarc_media_model import atarc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic [ATARC_LBA_W-1:0] err_lba,
  input wire logic med_req,
  input wire logic [ATARC_LBA_W-1:0] med_lba,
  output logic med_valid,
  output logic [31:0] med_data,
  output logic med_done,
  output logic med_err,
  output int req_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ATARC_LBA_W-1:0] lba_q;
  int ph;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph <= 0;
      req_cnt <= 0;
      med_valid <= 1'b0;
      med_done <= 1'b0;
      med_err <= 1'b0;
      med_data <= 32'h0;
    end else begin
      med_valid <= 1'b0;
      med_done <= 1'b0;
      med_err <= 1'b0;
      // Idle data toggles so a stale word can never pass for a fresh one
      med_data <= ~med_data;
      if (med_req) begin
        lba_q <= med_lba;
        req_cnt <= req_cnt + 1;
        ph <= 1;
      end else if (ph != 0 && !slow) begin
        ph <= (ph == 130) ? 0 : ph + 1;
        if (ph >= 2 && ph < 130) begin
          med_valid <= 1'b1;
          med_data <= {lba_q[23:0], 8'(ph - 2)};
        end
        if (ph == 130) begin
          med_done <= 1'b1;
          med_err <= (lba_q == err_lba);
        end
      end
    end
  end
endmodule // atarc_media_model

// *** atarc_pkg.sv ***
/*
  Constants, register map and carrier types of the ATA read-command handler.
  Assumes one 100 MHz clock and an APB master with 32-bit data.
*/
// How it works
// [R1] F8h fetches native max address, no data
// [R2] Host sets LBA bit for native query; the core ignores the LBA bit and always uses LBA addressing
// [R3] Host picks drive with device-select bit; the core takes commands whatever that bit holds
// [R4] Native max LBA lands in address registers
// [R5] 20h and 21h read 1 to 256 sectors
// [R6] Count zero means 256 sectors
// [R7] Read starts at given address, goes consecutive
// [R8] Per sector: busy, fill, request, interrupt
// [R9] Host reads 512 bytes per request
// [R10] Read error stops, failing address reported
// [R11] Flawed sector data stays in buffer
// [R12] 40h and 41h verify, never request data
// [R13] Verify: busy, then one completion interrupt
// [R14] Verify error stops, failing address reported
// [R15] Verify error leaves unverified count
// [R16] Any 1Xh completes as no-operation
// [R17] LBA built from head, high, mid, low
// [R18] Count decrements, address advances per sector
package atarc_pkg;

  localparam int ATARC_AW = 8;
  localparam int ATARC_LBA_W = 28;
  localparam int ATARC_CNT_W = 9;
  localparam int ATARC_WIDX_W = 7;
  localparam int ATARC_SECT_WORDS = 128;

  // Register byte offsets
  localparam logic [ATARC_AW-1:0] OFF_DATA = 8'h00;
  localparam logic [ATARC_AW-1:0] OFF_FEATURE = 8'h04;
  localparam logic [ATARC_AW-1:0] OFF_COUNT = 8'h08;
  localparam logic [ATARC_AW-1:0] OFF_ADDR_LOW = 8'h0c;
  localparam logic [ATARC_AW-1:0] OFF_ADDR_MID = 8'h10;
  localparam logic [ATARC_AW-1:0] OFF_ADDR_HIGH = 8'h14;
  localparam logic [ATARC_AW-1:0] OFF_DEV_HEAD = 8'h18;
  localparam logic [ATARC_AW-1:0] OFF_CMD_STAT = 8'h1c;
  localparam logic [ATARC_AW-1:0] OFF_IRQ_STS = 8'h20;
  localparam logic [ATARC_AW-1:0] OFF_IRQ_MASK = 8'h24;

  // Opcodes
  localparam logic [7:0] OP_NATIVE_MAX = 8'hf8;
  localparam logic [7:0] OP_READ_A = 8'h20;
  localparam logic [7:0] OP_READ_B = 8'h21;
  localparam logic [7:0] OP_VERIFY_A = 8'h40;
  localparam logic [7:0] OP_VERIFY_B = 8'h41;
  localparam logic [3:0] OP_RECAL_HI = 4'h1;

  // Field positions and fixed values
  localparam int IRQ_SECT = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_ERR = 2;
  localparam logic [ATARC_CNT_W-1:0] CNT_FULL = 9'h100;
  localparam logic [ATARC_CNT_W-1:0] CNT_ONE = 9'h001;
  localparam logic [ATARC_WIDX_W-1:0] WIDX_LAST = 7'h7f;
  localparam logic [ATARC_LBA_W-1:0] LBA_ONE = 28'h0000001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_XFER = 3'b100
  } atarc_state_t;

  typedef struct packed {
    logic err;
    logic drq;
    logic busy;
  } atarc_stat_t;

  typedef struct packed {
    logic [3:0] head;
    logic [7:0] high;
    logic [7:0] mid;
    logic [7:0] low;
  } atarc_addr_t;

endpackage

// *** tb.sv ***
/*
  Self-checking bench of the read-command handler over APB with a media model.
  Assumes zero-wait APB answers and the register map of the package.
*/
module tb import atarc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow_en = 1'b0;
  logic [ATARC_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, med_data, r;
  logic pready, pslverr, irq, med_req, med_valid, med_done, med_err, slow, perr;
  logic [ATARC_LBA_W-1:0] med_lba, err_lba = 28'hfffffff, native_max = 28'h9abcdef;
  int fails = 0, n_tests = 0, cyc = 0, req_cnt, n0;
  localparam logic [7:0] RA[8] = '{OFF_FEATURE, OFF_COUNT, OFF_ADDR_LOW, OFF_ADDR_MID,
    OFF_ADDR_HIGH, OFF_DEV_HEAD, OFF_IRQ_MASK, 8'h28};
  localparam logic [31:0] RW[8] = '{32'h3c, 32'h81, 32'ha5, 32'h5a, 32'hc3, 32'he7, 32'h7, 32'h12};
  localparam logic [31:0] RE[8] = '{32'h3c, 32'h81, 32'ha5, 32'h5a, 32'hc3, 32'he7, 32'h7, 32'h0};
  assign slow = slow_en & cyc[0];
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  atarc_core i_atarc_core (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .MED_REQ(med_req), .MED_LBA(med_lba),
    .MED_VALID(med_valid), .MED_DATA(med_data), .MED_DONE(med_done), .MED_ERR(med_err),
    .NATIVE_MAX(native_max));
  atarc_media_model i_atarc_media_model (.clk(clk), .nrst(nrst), .slow(slow),
    .err_lba(err_lba), .med_req(med_req), .med_lba(med_lba), .med_valid(med_valid),
    .med_data(med_data), .med_done(med_done), .med_err(med_err), .req_cnt(req_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails = fails + 1;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls status; a bounded count keeps a stuck busy from hanging the run
  task automatic wait_st(input logic [2:0] m, input logic [2:0] v, input logic nd);
    for (int k = 0; k < 20000; k++) begin
      apb(1'b0, OFF_CMD_STAT, 32'h0);
      if (nd) chk(32'(r[1]), 32'h0);
      if ((r[2:0] & m) === v) break;
    end
    chk(32'(r[2:0] & m), 32'(v));
  endtask
  task automatic setup(input logic [27:0] a, input logic [7:0] c);
    apb(1'b1, OFF_ADDR_LOW, 32'(a[7:0]));
    apb(1'b1, OFF_ADDR_MID, 32'(a[15:8]));
    apb(1'b1, OFF_ADDR_HIGH, 32'(a[23:16]));
    apb(1'b1, OFF_DEV_HEAD, {24'h0, 4'he, a[27:24]});
    apb(1'b1, OFF_COUNT, 32'(c));
  endtask
  task automatic chk_addr(input logic [27:0] a);
    apb(1'b0, OFF_ADDR_LOW, 32'h0);
    chk(r, 32'(a[7:0]));
    apb(1'b0, OFF_ADDR_MID, 32'h0);
    chk(r, 32'(a[15:8]));
    apb(1'b0, OFF_ADDR_HIGH, 32'h0);
    chk(r, 32'(a[23:16]));
    apb(1'b0, OFF_DEV_HEAD, 32'h0);
    chk(r, {24'h0, 4'he, a[27:24]});
  endtask
  task automatic drain(input logic [27:0] a);
    for (int i = 0; i < ATARC_SECT_WORDS; i++) begin
      apb(1'b0, OFF_DATA, 32'h0);
      chk(r, {a[23:0], 8'(i)});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, OFF_IRQ_STS, 32'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk(r, 32'h0);
      apb(1'b1, RA[i], RW[i]);
      chk(32'(perr), 32'(i == 7));
      apb(1'b0, RA[i], 32'h0);
      chk(r, RE[i]);
    end
    apb(1'b1, OFF_DEV_HEAD, 32'he0);
    apb(1'b1, OFF_CMD_STAT, 32'(OP_NATIVE_MAX));
    wait_st(3'b111, 3'b000, 1'b1);
    chk_addr(native_max);
    apb(1'b0, OFF_IRQ_STS, 32'h0);
    chk(r, 32'h2);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFF_IRQ_STS, 32'h2);
    #1 chk(32'(irq), 32'h0);
    // Every 1Xh code, done interrupt masked off
    apb(1'b1, OFF_IRQ_MASK, 32'h5);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, OFF_CMD_STAT, {24'h0, OP_RECAL_HI, 4'(i)});
      wait_st(3'b111, 3'b000, 1'b1);
      apb(1'b0, OFF_IRQ_STS, 32'h0);
      chk(r, 32'h2);
      chk(32'(irq), 32'h0);
      apb(1'b1, OFF_IRQ_STS, 32'h2);
    end
    // An opcode outside the handled set is refused with an error
    apb(1'b1, OFF_CMD_STAT, 32'h0);
    wait_st(3'b111, 3'b100, 1'b1);
    apb(1'b0, OFF_IRQ_STS, 32'h0);
    chk(r, 32'h4);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFF_IRQ_STS, 32'h4);
    chk_addr(native_max);
    apb(1'b1, OFF_IRQ_MASK, 32'h7);
    for (int k = 0; k < 2; k++) begin
      n0 = req_cnt;
      slow_en <= (k == 1);
      setup(28'h12301fe + k, 8'h02);
      apb(1'b1, OFF_CMD_STAT, 32'(k ? OP_READ_B : OP_READ_A));
      for (int s = 0; s < 2; s++) begin
        wait_st(3'b111, 3'b010, 1'b0);
        apb(1'b0, OFF_IRQ_STS, 32'h0);
        chk(r, 32'h1);
        apb(1'b1, OFF_IRQ_STS, 32'h1);
        drain(28'h12301fe + k + s);
      end
      wait_st(3'b111, 3'b000, 1'b0);
      chk(req_cnt - n0, 32'h2);
      apb(1'b0, OFF_IRQ_STS, 32'h0);
      chk(r, 32'h0);
    end
    slow_en <= 1'b0;
    err_lba <= 28'h0abcd01;
    setup(28'h0abcd00, 8'h03);
    apb(1'b1, OFF_CMD_STAT, 32'(OP_READ_A));
    wait_st(3'b111, 3'b010, 1'b0);
    drain(28'h0abcd00);
    wait_st(3'b111, 3'b100, 1'b1);
    chk_addr(28'h0abcd01);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk(r, 32'h2);
    apb(1'b0, OFF_IRQ_STS, 32'h0);
    chk(32'(r[2]), 32'h1);
    drain(28'h0abcd01);
    apb(1'b1, OFF_IRQ_STS, 32'h7);
    err_lba <= 28'hfffffff;
    n0 = req_cnt;
    setup(28'h0000100, 8'h00);
    apb(1'b1, OFF_CMD_STAT, 32'(OP_VERIFY_A));
    wait_st(3'b111, 3'b000, 1'b1);
    chk(req_cnt - n0, 32'h100);
    apb(1'b0, OFF_IRQ_STS, 32'h0);
    chk(r, 32'h2);
    apb(1'b1, OFF_IRQ_STS, 32'h2);
    err_lba <= 28'h0000203;
    setup(28'h0000200, 8'h05);
    apb(1'b1, OFF_CMD_STAT, 32'(OP_VERIFY_B));
    wait_st(3'b111, 3'b100, 1'b1);
    chk_addr(28'h0000203);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk(r, 32'h2);
    // Reset in the middle of a read brings everything back to idle
    err_lba <= 28'hfffffff;
    setup(28'h0000300, 8'h02);
    apb(1'b1, OFF_CMD_STAT, 32'(OP_READ_A));
    wait_st(3'b111, 3'b010, 1'b0);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'b0, OFF_CMD_STAT, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, OFF_IRQ_MASK, 32'h0);
    chk(r, 32'h0);
    final_report();
  end
endmodule // tb
